// ---- common/eic_pkg.sv ----
// Constants for the external interrupt level and trigger configuration block
`default_nettype none
package eic_pkg;
	localparam int unsigned NUM_SRC    = 8;
	localparam int unsigned LVL_W      = 3;
	localparam int unsigned REG_W      = 16;

	// Printed register indexes; byte address is four times the index
	localparam logic [31:0] IDX_CFG_PORTS     = 32'h0000_4306;
	localparam logic [31:0] IDX_CFG_CLK_SWT   = 32'h0000_4308;
	localparam logic [31:0] IDX_CFG_VOLT_SUB  = 32'h0000_430A;
	localparam logic [31:0] IDX_CFG_PWM_LCD   = 32'h0000_430C;
	localparam logic [31:0] IDX_SRC_ENABLE    = 32'h0000_4300;
	localparam logic [31:0] IDX_SRC_FLAG      = 32'h0000_4302;
	localparam logic [31:0] IDX_EVT_STATUS    = 32'h0000_4320;
	localparam logic [31:0] IDX_EVT_MASK      = 32'h0000_4322;
	localparam int unsigned ADDR_SHIFT        = 2;

	// Field layout of each level register: low source, high source
	localparam int unsigned LO_LVL_LSB = 0;
	localparam int unsigned LO_TRG_BIT = 4;
	localparam int unsigned HI_LVL_LSB = 8;
	localparam int unsigned HI_TRG_BIT = 12;

	localparam logic       TRIG_RESET  = 1'h0;
	localparam logic [2:0] LVL_RESET   = 3'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [1:0] HRESP_OKAY  = 2'h0;
	localparam logic [1:0] HTRANS_NSEQ = 2'h2;
endpackage
`default_nettype wire

// ---- common/eic_src_if.sv ----
// Link between the controller core and one source sampler
`timescale 1ns/1ns
`default_nettype none
interface eic_src_if;
	logic trig_level;
	logic src_in;
	logic clr;
	logic flag;
	modport smp (input trig_level, input src_in, input clr, output flag);
	modport ctl (output trig_level, output src_in, output clr, input flag);
endinterface
`default_nettype wire

// ---- hw/eic_sampler.sv ----
// Per-source synchroniser and pending flag in pulse or level mode
`timescale 1ns/1ns
`default_nettype none
module eic_sampler (
	input  wire logic clk,
	input  wire logic rst,
	eic_src_if.smp    port
);
	logic sync1_q;
	logic sync2_q;
	logic flag_q;

	// Source may come from the sub-clock side, so two stages first
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= port.src_in;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (port.trig_level) begin
			flag_q <= sync2_q;
		end else if (!flag_q) begin
			flag_q <= sync2_q;
		end else if (port.clr) begin
			flag_q <= 1'b0;
		end
	end

	assign port.flag = flag_q;
endmodule
`default_nettype wire

// ---- hw/eic_top.sv ----
// External interrupt trigger and level configuration with priority resolver
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module eic_top #(
	parameter int unsigned NSRC = eic_pkg::NUM_SRC
) (
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	input  wire logic                  HSEL,
	input  wire logic [31:0]           HADDR,
	input  wire logic [1:0]            HTRANS,
	input  wire logic                  HWRITE,
	input  wire logic [2:0]            HSIZE,
	input  wire logic [31:0]           HWDATA,
	input  wire logic                  HREADY,
	output logic      [31:0]           HRDATA,
	output logic                       HREADYOUT,
	output logic      [1:0]            HRESP,
	input  wire logic [NSRC-1:0]       SRC_IN,
	output logic      [NSRC-1:0]       SRC_FLAG,
	output logic      [NSRC-1:0]       TRIG_MODE,
	output logic      [3*NSRC-1:0]     SRC_LEVEL,
	output logic                       REQ,
	output logic      [2:0]            REQ_VECTOR,
	output logic      [2:0]            REQ_LEVEL,
	output logic                       IRQ
);
	localparam int unsigned NREG = NSRC / 2;

	logic [NSRC-1:0]  trig_q;
	logic [2:0]       lvl_q [NSRC];
	logic [NSRC-1:0]  enable_q;
	logic [NSRC-1:0]  status_q;
	logic [NSRC-1:0]  mask_q;
	logic [NSRC-1:0]  flag;
	logic [NSRC-1:0]  flag_prev_q;
	logic [NSRC-1:0]  flag_clr;

	logic             wr_pend_q;
	logic             rd_pend_q;
	logic [NREG-1:0]  cfg_hit_q;
	logic             en_hit_q;
	logic             flg_hit_q;
	logic             sts_hit_q;
	logic             msk_hit_q;
	logic [31:0]      hrdata_q;
	logic             hready_q;
	logic [1:0]       hresp_q;

	logic             req_q;
	logic [2:0]       vec_q;
	logic [2:0]       rlvl_q;
	logic             irq_q;

	logic             addr_phase;
	logic             wr_en;
	logic [31:0]      rd_mux;
	logic             win_found;
	logic [2:0]       win_vec;
	logic [2:0]       win_lvl;

	logic [NREG-1:0]  cfg_we;
	logic             en_we;
	logic             flg_we;
	logic             sts_we;
	logic             msk_we;
	logic [31:0]      cfg_word [NREG];
	logic [NSRC-1:0]  flag_rise;

	// Sources per level register: low field source 2r, high field source 2r+1
	function automatic logic [31:0] cfg_addr(input int unsigned r);
		logic [31:0] idx;
		case (r)
			0:       idx = eic_pkg::IDX_CFG_PORTS;
			1:       idx = eic_pkg::IDX_CFG_CLK_SWT;
			2:       idx = eic_pkg::IDX_CFG_VOLT_SUB;
			default: idx = eic_pkg::IDX_CFG_PWM_LCD;
		endcase
		return idx << eic_pkg::ADDR_SHIFT;
	endfunction

	function automatic logic [31:0] own_addr(input logic [31:0] idx);
		return idx << eic_pkg::ADDR_SHIFT;
	endfunction

	// Samplers
	eic_src_if src [NSRC] ();

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			assign src[gi].trig_level = trig_q[gi];
			assign src[gi].src_in     = SRC_IN[gi];
			assign src[gi].clr        = flag_clr[gi];
			assign flag[gi]           = src[gi].flag;
			eic_sampler u_smp (
				.clk  (CLK),
				.rst  (SYS_RST),
				.port (src[gi])
			);
		end
	endgenerate

	// Bus slave: writes commit in the data phase, reads take one wait state
	assign addr_phase = HSEL && HREADY && (HTRANS == eic_pkg::HTRANS_NSEQ);
	assign wr_en      = wr_pend_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			hready_q  <= 1'b1;
			hresp_q   <= eic_pkg::HRESP_OKAY;
		end else begin
			wr_pend_q <= addr_phase && HWRITE;
			hresp_q   <= eic_pkg::HRESP_OKAY;
			if (addr_phase && !HWRITE) begin
				rd_pend_q <= 1'b1;
				hready_q  <= 1'b0;
			end else if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				hready_q  <= 1'b1;
			end
		end
	end

	// Decode in the address phase so the data phase sees one flat hit per register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cfg_hit_q <= '0;
			en_hit_q  <= 1'b0;
			flg_hit_q <= 1'b0;
			sts_hit_q <= 1'b0;
			msk_hit_q <= 1'b0;
		end else if (addr_phase) begin
			for (int unsigned r = 0; r < NREG; r++) begin
				cfg_hit_q[r] <= (HADDR == cfg_addr(r));
			end
			en_hit_q  <= (HADDR == own_addr(eic_pkg::IDX_SRC_ENABLE));
			flg_hit_q <= (HADDR == own_addr(eic_pkg::IDX_SRC_FLAG));
			sts_hit_q <= (HADDR == own_addr(eic_pkg::IDX_EVT_STATUS));
			msk_hit_q <= (HADDR == own_addr(eic_pkg::IDX_EVT_MASK));
		end
	end

	// Hits stay after the transfer, so every strobe is gated by the data phase
	always_comb begin
		cfg_we = '0;
		for (int unsigned r = 0; r < NREG; r++) begin
			cfg_we[r] = wr_en && cfg_hit_q[r];
		end
		en_we  = wr_en && en_hit_q;
		flg_we = wr_en && flg_hit_q;
		sts_we = wr_en && sts_hit_q;
		msk_we = wr_en && msk_hit_q;
	end

	// Low source in D4 and D2:0, high source in D12 and D10:8, the rest zero
	always_comb begin
		for (int unsigned r = 0; r < NREG; r++) begin
			cfg_word[r]                           = 32'h0000_0000;
			cfg_word[r][eic_pkg::LO_LVL_LSB +: 3] = lvl_q[2*r];
			cfg_word[r][eic_pkg::LO_TRG_BIT]      = trig_q[2*r];
			cfg_word[r][eic_pkg::HI_LVL_LSB +: 3] = lvl_q[2*r+1];
			cfg_word[r][eic_pkg::HI_TRG_BIT]      = trig_q[2*r+1];
		end
	end

	// Read data sampled after any preceding write has landed
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int unsigned r = 0; r < NREG; r++) begin
			if (cfg_hit_q[r]) begin
				rd_mux = cfg_word[r];
			end
		end
		if (en_hit_q) begin
			rd_mux[NSRC-1:0] = enable_q;
		end
		if (flg_hit_q) begin
			rd_mux[NSRC-1:0] = flag;
		end
		if (sts_hit_q) begin
			rd_mux[NSRC-1:0] = status_q;
		end
		if (msk_hit_q) begin
			rd_mux[NSRC-1:0] = mask_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			hrdata_q <= rd_mux;
		end
	end

	// Trigger-mode bits
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			for (int unsigned i = 0; i < NSRC; i++) begin
				trig_q[i] <= eic_pkg::TRIG_RESET;
			end
		end else begin
			for (int unsigned r = 0; r < NREG; r++) begin
				if (cfg_we[r]) begin
					trig_q[2*r]   <= HWDATA[eic_pkg::LO_TRG_BIT];
					trig_q[2*r+1] <= HWDATA[eic_pkg::HI_TRG_BIT];
				end
			end
		end
	end

	// Level fields
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			for (int unsigned i = 0; i < NSRC; i++) begin
				lvl_q[i] <= eic_pkg::LVL_RESET;
			end
		end else begin
			for (int unsigned r = 0; r < NREG; r++) begin
				if (cfg_we[r]) begin
					lvl_q[2*r]   <= HWDATA[eic_pkg::LO_LVL_LSB +: 3];
					lvl_q[2*r+1] <= HWDATA[eic_pkg::HI_LVL_LSB +: 3];
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			enable_q <= eic_pkg::BYTE_RESET;
		end else if (en_we) begin
			enable_q <= HWDATA[NSRC-1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mask_q <= eic_pkg::BYTE_RESET;
		end else if (msk_we) begin
			mask_q <= HWDATA[NSRC-1:0];
		end
	end

	// Write one to a flag; only pulse-mode flags honour it
	always_comb begin
		flag_clr = '0;
		if (flg_we) begin
			flag_clr = HWDATA[NSRC-1:0] & ~trig_q;
		end
	end

	// Previous flags reset low like the flags, so no false edge follows reset
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			flag_prev_q <= eic_pkg::BYTE_RESET;
		end else begin
			flag_prev_q <= flag;
		end
	end

	assign flag_rise = flag & ~flag_prev_q;

	// Sticky event status: a rising flag sets, write one clears, set wins
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			status_q <= eic_pkg::BYTE_RESET;
		end else if (sts_we) begin
			status_q <= (status_q & ~HWDATA[NSRC-1:0]) | flag_rise;
		end else begin
			status_q <= status_q | flag_rise;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// Resolver scans downward so equal levels fall to the smaller vector
	always_comb begin
		win_found = 1'b0;
		win_vec   = 3'h0;
		win_lvl   = 3'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (flag[i] && enable_q[i] && (!win_found || lvl_q[i] >= win_lvl)) begin
				win_found = 1'b1;
				win_vec   = 3'(i);
				win_lvl   = lvl_q[i];
			end
		end
	end

	// Re-resolved every cycle, so a higher arrival replaces the output
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			req_q  <= 1'b0;
			vec_q  <= 3'h0;
			rlvl_q <= 3'h0;
		end else begin
			req_q  <= win_found;
			vec_q  <= win_vec;
			rlvl_q <= win_lvl;
		end
	end

	always_comb begin
		for (int unsigned i = 0; i < NSRC; i++) begin
			SRC_LEVEL[3*i +: 3] = lvl_q[i];
		end
	end

	assign HRDATA     = hrdata_q;
	assign HREADYOUT  = hready_q;
	assign HRESP      = hresp_q;
	assign SRC_FLAG   = flag;
	assign TRIG_MODE  = trig_q;
	assign REQ        = req_q;
	assign REQ_VECTOR = vec_q;
	assign REQ_LEVEL  = rlvl_q;
	assign IRQ        = irq_q;
endmodule
`default_nettype wire

// ---- test/eic_checker.sv ----
// Port-level assertions for the interrupt configuration block
`timescale 1ns/1ns
`default_nettype none
module eic_checker #(
	parameter int unsigned NSRC = 8
) (
	input wire logic              CLK,
	input wire logic              SYS_RST,
	input wire logic              HSEL,
	input wire logic [31:0]       HADDR,
	input wire logic [1:0]        HTRANS,
	input wire logic              HWRITE,
	input wire logic              HREADY,
	input wire logic [31:0]       HRDATA,
	input wire logic              HREADYOUT,
	input wire logic [1:0]        HRESP,
	input wire logic [NSRC-1:0]   SRC_IN,
	input wire logic [NSRC-1:0]   SRC_FLAG,
	input wire logic [NSRC-1:0]   TRIG_MODE,
	input wire logic [3*NSRC-1:0] SRC_LEVEL,
	input wire logic              REQ,
	input wire logic [2:0]        REQ_VECTOR,
	input wire logic [2:0]        REQ_LEVEL,
	input wire logic              IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic tk;
	assign tk = HSEL && HREADY && HTRANS == 2'h2;
	property p_rst; $fell(SYS_RST) |-> TRIG_MODE == '0 && SRC_LEVEL == '0; endproperty
	a_rst: assert property (p_rst) else $error("config not cleared by reset");
	// Four level-mode cycles so the flag has left any pulse-held state
	property p_lvl; TRIG_MODE[3] [*4] |-> SRC_FLAG[3] == $past(SRC_IN[3], 3); endproperty
	a_lvl: assert property (p_lvl) else $error("level flag not following input");
	property p_pulse;
		!TRIG_MODE[2] && $fell(SRC_FLAG[2]) |->
			$past(tk && HWRITE && HADDR == eic_pkg::IDX_SRC_FLAG << eic_pkg::ADDR_SHIFT, 2);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse flag dropped without clear");
	property p_req; !$past(|SRC_FLAG) |-> !REQ; endproperty
	a_req: assert property (p_req) else $error("request without pending flag");
	property p_lvm; REQ |-> REQ_LEVEL == 3'($past(SRC_LEVEL) >> (3 * REQ_VECTOR)); endproperty
	a_lvm: assert property (p_lvm) else $error("request level not that of vector");
	property p_wait; tk && !HWRITE |=> !HREADYOUT; endproperty
	a_wait: assert property (p_wait) else $error("read without wait state");
	property p_one; !HREADYOUT |=> HREADYOUT; endproperty
	a_one: assert property (p_one) else $error("wait state too long");
	property p_upper; HRDATA[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	property p_okay; HRESP == eic_pkg::HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	c_top: cover property (REQ && REQ_LEVEL == 3'h7);
	c_clr: cover property ($fell(SRC_FLAG[2]));
	c_irq: cover property (IRQ);
endmodule
bind eic_top eic_checker #(.NSRC(NSRC)) u_eic_checker (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
	.HREADY, .HRDATA, .HREADYOUT, .HRESP, .SRC_IN, .SRC_FLAG, .TRIG_MODE, .SRC_LEVEL, .REQ, .REQ_VECTOR, .REQ_LEVEL,
	.IRQ);
`default_nettype wire

// ---- test/eic_src_model.sv ----
// Source-side model: each request line held until told to drop
`timescale 1ns/1ns
`default_nettype none
module eic_src_model (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] raise,
	input wire logic [7:0] drop,
	output logic     [7:0] src
);
	always_ff @(posedge clk) begin
		if (rst) begin
			src <= 8'h00;
		end else begin
			src <= (src | raise) & ~drop;
		end
	end
endmodule
`default_nettype wire

// ---- test/eic_top_test.sv ----
// Self-checking bench for the interrupt configuration block
`timescale 1ns/1ns
`default_nettype none
module eic_top_test;
	logic        CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, REQ, IRQ;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0]  HTRANS, HRESP;
	logic [2:0]  REQ_VECTOR, REQ_LEVEL;
	logic [7:0]  raise, drop, SRC_IN, SRC_FLAG, TRIG_MODE;
	logic [23:0] SRC_LEVEL;
	int          mismatches = 0;
	int          samples_checked = 0;
	always #2 CLK = ~CLK;
	eic_top #(.NSRC(8)) u_eic_top (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
		.HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SRC_IN, .SRC_FLAG, .TRIG_MODE, .SRC_LEVEL, .REQ,
		.REQ_VECTOR, .REQ_LEVEL, .IRQ);
	eic_src_model u_eic_src_model (.clk(CLK), .rst(SYS_RST), .raise, .drop, .src(SRC_IN));
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic xf(logic w, logic [31:0] idx, logic [31:0] d);
		HADDR <= idx << eic_pkg::ADDR_SHIFT;
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'h1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'h1);
		rd = HRDATA;
	endtask
	task automatic rchk(string n, logic [31:0] idx, logic [31:0] e);
		xf(1'h0, idx, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic pulse(logic [7:0] m, logic up);
		if (up) raise <= m;
		else drop <= m;
		cyc(1);
		{raise, drop} <= 16'h0000;
		cyc(6);
	endtask
	task automatic final_report;
		$display("Checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		final_report();
	end
	initial begin
		logic [31:0] a, d;
		{CLK, SYS_RST, HSEL, HWRITE, HTRANS, HADDR, HWDATA, raise, drop} = '0;
		SYS_RST = 1'h1;
		cyc(20);
		SYS_RST <= 1'h0;
		HSEL <= 1'h1;
		for (int r = 0; r < 4; r++) begin
			a = eic_pkg::IDX_CFG_PORTS + 2 * r;
			d = 32'h1000 | (r + 1) << 8 | (r + 4);
			rchk("cfg reset", a, 32'h0);
			xf(1'h1, a, 32'hFFFF_FFFF);
			rchk("cfg ones", a, 32'h1717);
			xf(1'h1, a, d);
			rchk("cfg map", a, d);
			chk("trig hi", 1, TRIG_MODE[2 * r + 1]);
			chk("trig lo", 0, TRIG_MODE[2 * r]);
			chk("lvl hi", r + 1, SRC_LEVEL[6 * r + 3 +: 3]);
			chk("lvl lo", r + 4, SRC_LEVEL[6 * r +: 3]);
		end
		xf(1'h1, 32'h4340, 32'hFFFF_FFFF);
		rchk("unmapped", 32'h4340, 32'h0);
		$display("Test register map done");
		for (int r = 0; r < 4; r++) xf(1'h1, eic_pkg::IDX_CFG_PORTS + 2 * r, r[0] ? 32'h1515 | r[1] << 1 : 32'h1010);
		xf(1'h1, eic_pkg::IDX_SRC_ENABLE, 32'hFF);
		pulse(8'h88, 1'h1);
		chk("vec tie", 3, REQ_VECTOR);
		chk("lvl tie", 5, REQ_LEVEL);
		pulse(8'h40, 1'h1);
		chk("vec new", 6, REQ_VECTOR);
		chk("lvl new", 7, REQ_LEVEL);
		pulse(8'h40, 1'h0);
		chk("vec back", 3, REQ_VECTOR);
		xf(1'h1, eic_pkg::IDX_SRC_ENABLE, 32'hBF);
		pulse(8'h40, 1'h1);
		chk("vec disabled", 3, REQ_VECTOR);
		chk("lvl disabled", 5, REQ_LEVEL);
		pulse(8'h40, 1'h0);
		xf(1'h1, eic_pkg::IDX_SRC_ENABLE, 32'hFF);
		xf(1'h1, eic_pkg::IDX_SRC_FLAG, 32'hFF);
		cyc(2);
		chk("flag w1", 8'h88, SRC_FLAG);
		rchk("flag reg", eic_pkg::IDX_SRC_FLAG, 32'h88);
		chk("irq masked", 0, IRQ);
		pulse(8'h88, 1'h0);
		chk("flag low", 0, SRC_FLAG);
		chk("req idle", 0, REQ);
		$display("Test level priority done");
		xf(1'h1, eic_pkg::IDX_CFG_CLK_SWT, 32'h1505);
		xf(1'h1, eic_pkg::IDX_EVT_STATUS, 32'hFF);
		xf(1'h1, eic_pkg::IDX_EVT_MASK, 32'h04);
		raise <= 8'h04;
		cyc(1);
		pulse(8'h04, 1'h0);
		chk("pulse held", 1, SRC_FLAG[2]);
		chk("irq set", 1, IRQ);
		xf(1'h1, eic_pkg::IDX_SRC_FLAG, 32'h04);
		cyc(2);
		chk("pulse clr", 0, SRC_FLAG[2]);
		xf(1'h1, eic_pkg::IDX_EVT_STATUS, 32'h04);
		cyc(2);
		chk("irq clr", 0, IRQ);
		$display("Test pulse interrupt done");
		final_report();
	end
endmodule
`default_nettype wire
